// >>> design/usc_pkg.sv
package usc_pkg;

  // Register addresses
  localparam logic [15:0] USC_ADDR_RX_ERR   = 16'hff53;
  localparam logic [15:0] USC_ADDR_TX_STAT  = 16'hff55;
  localparam logic [15:0] USC_ADDR_CLK_SEL  = 16'hff56;

  // Reset values
  localparam logic [7:0]  USC_RX_ERR_RST    = 8'h00;
  localparam logic [7:0]  USC_TX_STAT_RST   = 8'h00;
  localparam logic [7:0]  USC_CLK_SEL_RST   = 8'h00;
  localparam logic [7:0]  USC_READ_ZERO     = 8'h00;
  localparam logic [7:0]  USC_TXBUF_RST     = 8'hff;

  // Field positions
  localparam int          USC_BIT_OVERRUN   = 0;
  localparam int          USC_BIT_FRAMING   = 1;
  localparam int          USC_BIT_PARITY    = 2;
  localparam int          USC_BIT_SHIFT     = 0;
  localparam int          USC_BIT_BUFFULL   = 1;
  localparam int          USC_SEL_MSB       = 3;

  // Select codes
  localparam logic [3:0]  USC_SEL_MAX_DIV   = 4'ha;
  localparam logic [3:0]  USC_SEL_TIMER     = 4'hb;
  localparam int          USC_DIV_W         = 11;

  // Bus read takes one wait cycle on the error status register
  localparam logic [1:0]  USC_WAIT_CYCLES   = 2'h1;

  typedef enum logic [1:0] {
    USC_PAR_NONE = 2'b00,
    USC_PAR_ZERO = 2'b01,
    USC_PAR_ODD  = 2'b10,
    USC_PAR_EVEN = 2'b11
  } usc_parity_t;

  // Completed reception as delivered by the receive shifter
  typedef struct packed {
    logic [7:0] data;
    logic       parity_bit;
    logic       stop_bit;
    logic       char8;
  } usc_rx_char_t;

  // Register bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } usc_bus_req_t;

endpackage

// >>> design/usc_fifo.sv
`timescale 1ns/1ps
module usc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/usc_status_clock.sv
`timescale 1ns/1ps
module usc_status_clock
  import usc_pkg::*;
#(
  parameter int RX_FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 SRST,
  // Register bus
  input  wire usc_pkg::usc_bus_req_t BUS_REQ,
  output logic                      BUS_WAIT,
  output logic                      BUS_RVALID,
  output logic [7:0]                BUS_RDATA,
  // Unit controls from the mode register
  input  wire logic                 UNIT_POWER_ENABLE,
  input  wire logic                 RECEIVE_ENABLE,
  input  wire logic                 TRANSMIT_ENABLE,
  input  wire usc_pkg::usc_parity_t PARITY_MODE_SELECT,
  // Base clock
  input  wire logic                 TIMER_CLOCK_SOURCE,
  output logic                      SERIAL_BASE_CLOCK,
  // Receive side
  input  wire logic                 RX_DONE,
  input  wire usc_pkg::usc_rx_char_t RX_CHAR,
  input  wire logic                 RX_BUF_RD,
  output logic [7:0]                RECEIVE_BUFFER,
  output logic                      RX_BUF_VALID,
  output logic                      RX_ERROR,
  // Transmit side
  input  wire logic                 TX_BUF_WR,
  input  wire logic [7:0]           TX_BUF_WDATA,
  input  wire logic                 TX_SHIFT_DONE,
  output logic                      TX_SHIFT_LOAD,
  output logic [7:0]                TX_SHIFT_DATA,
  output logic                      TX_COMPLETE
);
  import usc_pkg::*;

  // Unit-wide clear, held off power or enables
  wire         rx_clear = SRST || !UNIT_POWER_ENABLE || !RECEIVE_ENABLE;
  wire         tx_clear = SRST || !UNIT_POWER_ENABLE || !TRANSMIT_ENABLE;

  // Timer output comes from another clock's logic, two-stage sync
  logic        tmr_s1_reg;
  logic        tmr_s2_reg;
  logic        tmr_s3_reg;
  always_ff @(posedge CLK) begin
    tmr_s1_reg <= TIMER_CLOCK_SOURCE;
    tmr_s2_reg <= tmr_s1_reg;
    tmr_s3_reg <= tmr_s2_reg;
  end

  // Register decode
  wire         hit_rx_err  = (BUS_REQ.addr == USC_ADDR_RX_ERR);
  wire         hit_tx_stat = (BUS_REQ.addr == USC_ADDR_TX_STAT);
  wire         hit_clk_sel = (BUS_REQ.addr == USC_ADDR_CLK_SEL);
  wire         clk_sel_wr  = BUS_REQ.wr && hit_clk_sel;

  // Error status read is held one extra cycle before data returns
  logic [1:0]  wait_cnt_reg;
  logic [1:0]  wait_cnt_next;
  wire         err_rd_start = BUS_REQ.rd && hit_rx_err && (wait_cnt_reg == 2'h0);
  wire         err_rd_fire  = (wait_cnt_reg == USC_WAIT_CYCLES);
  assign wait_cnt_next = err_rd_start ? USC_WAIT_CYCLES : 2'h0;
  assign BUS_WAIT      = err_rd_start;

  // Base clock select
  logic [7:0]  clk_sel_reg;
  logic [7:0]  clk_sel_next;
  wire  [3:0]  sel_code = clk_sel_reg[USC_SEL_MSB:0];
  assign clk_sel_next = clk_sel_wr ? {4'h0, BUS_REQ.wdata[USC_SEL_MSB:0]} : clk_sel_reg;

  // Base clock as a one-cycle enable: prescaler tap or timer edge
  logic [USC_DIV_W-1:0] presc_reg;
  logic                 base_tick;
  wire  [USC_DIV_W-1:0] presc_mask = USC_DIV_W'((1 << sel_code) - 1);
  wire                  timer_rise = tmr_s2_reg && !tmr_s3_reg;
  always_comb begin
    if (sel_code <= USC_SEL_MAX_DIV) begin
      base_tick = ((presc_reg & presc_mask) == '0);
    end else if (sel_code == USC_SEL_TIMER) begin
      base_tick = timer_rise;
    end else begin
      base_tick = 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST || !UNIT_POWER_ENABLE) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end
  // Base clock held low while the unit is off
  logic        base_clk_reg;
  always_ff @(posedge CLK) begin
    if (SRST || !UNIT_POWER_ENABLE) begin
      base_clk_reg <= 1'b0;
    end else begin
      base_clk_reg <= base_tick;
    end
  end
  assign SERIAL_BASE_CLOCK = base_clk_reg;

  // Receive checks on completion
  wire         par_calc   = ^RX_CHAR.data;
  logic        par_err;
  always_comb begin
    unique case (PARITY_MODE_SELECT)
      USC_PAR_NONE: par_err = 1'b0;
      USC_PAR_ZERO: par_err = 1'b0;
      USC_PAR_ODD:  par_err = (par_calc ^ RX_CHAR.parity_bit) != 1'b1;
      USC_PAR_EVEN: par_err = (par_calc ^ RX_CHAR.parity_bit) != 1'b0;
    endcase
  end
  wire         frm_err = !RX_CHAR.stop_bit;

  // Receive buffer: FIFO of characters, held back to one unread entry
  logic        rxf_in_ready;
  logic        rxf_out_valid;
  logic [7:0]  rxf_out_data;
  logic        rx_done_ok;
  wire         rx_unread = rxf_out_valid;
  wire         ovr_err   = RX_DONE && (rx_unread || !rxf_in_ready);
  assign rx_done_ok = RX_DONE && !ovr_err && !rx_clear;

  usc_fifo #(
    .WIDTH (8),
    .DEPTH (RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (CLK),
    .srst      (SRST),
    .flush     (rx_clear),
    .in_valid  (rx_done_ok),
    .in_ready  (rxf_in_ready),
    .in_data   (RX_CHAR.data),
    .out_valid (rxf_out_valid),
    .out_ready (RX_BUF_RD),
    .out_data  (rxf_out_data)
  );
  assign RECEIVE_BUFFER = rxf_out_data;
  assign RX_BUF_VALID   = rxf_out_valid;

  // Error flags
  logic [7:0]  rx_err_reg;
  logic [7:0]  rx_err_next;
  logic [7:0]  err_set;
  always_comb begin
    err_set = 8'h00;
    err_set[USC_BIT_PARITY]  = RX_DONE && par_err;
    err_set[USC_BIT_FRAMING] = RX_DONE && frm_err;
    err_set[USC_BIT_OVERRUN] = ovr_err;
  end
  // A new error in the reading cycle survives the clear
  assign rx_err_next = (err_rd_fire ? 8'h00 : rx_err_reg) | err_set;

  // Transmit buffer and shift register flags
  logic [7:0]  tx_buf_reg;
  logic        tx_full_reg;
  logic        tx_busy_reg;
  logic        tx_load_reg;
  logic [7:0]  tx_shift_reg;
  logic        tx_cmpl_reg;
  wire         tx_wr       = TX_BUF_WR && !tx_full_reg;
  wire         shift_free  = !tx_busy_reg || TX_SHIFT_DONE;
  // Writes while full are dropped, so software has to poll the full flag
  wire         tx_xfer     = tx_full_reg && shift_free;

  always_ff @(posedge CLK) begin
    if (tx_clear) begin
      tx_full_reg  <= 1'b0;
      tx_busy_reg  <= 1'b0;
      tx_load_reg  <= 1'b0;
      tx_cmpl_reg  <= 1'b0;
    end else begin
      tx_load_reg <= tx_xfer;
      tx_cmpl_reg <= TX_SHIFT_DONE && tx_busy_reg;
      if (tx_wr) begin
        tx_full_reg <= 1'b1;
      end else if (tx_xfer) begin
        tx_full_reg <= 1'b0;
      end
      if (tx_xfer) begin
        tx_busy_reg <= 1'b1;
      end else if (TX_SHIFT_DONE) begin
        tx_busy_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tx_buf_reg   <= USC_TXBUF_RST;
      tx_shift_reg <= USC_TXBUF_RST;
    end else begin
      if (tx_wr) begin
        tx_buf_reg <= TX_BUF_WDATA;
      end
      if (tx_xfer) begin
        tx_shift_reg <= tx_buf_reg;
      end
    end
  end
  assign TX_SHIFT_LOAD = tx_load_reg;
  assign TX_SHIFT_DATA = tx_shift_reg;
  assign TX_COMPLETE   = tx_cmpl_reg;

  // Status and select registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      clk_sel_reg  <= USC_CLK_SEL_RST;
      wait_cnt_reg <= 2'h0;
    end else begin
      clk_sel_reg  <= clk_sel_next;
      wait_cnt_reg <= wait_cnt_next;
    end
  end
  always_ff @(posedge CLK) begin
    if (rx_clear) begin
      rx_err_reg <= USC_RX_ERR_RST;
    end else begin
      rx_err_reg <= rx_err_next;
    end
  end

  // Read data path
  logic [7:0]  tx_stat;
  always_comb begin
    tx_stat = USC_TX_STAT_RST;
    tx_stat[USC_BIT_BUFFULL] = tx_full_reg;
    tx_stat[USC_BIT_SHIFT]   = tx_busy_reg;
  end
  logic [7:0]  rdata_reg;
  logic        rvalid_reg;
  wire         plain_rd = BUS_REQ.rd && !hit_rx_err;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_reg  <= USC_READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= plain_rd || err_rd_fire;
      if (err_rd_fire) begin
        rdata_reg <= rx_err_reg;
      end else if (plain_rd && hit_tx_stat) begin
        rdata_reg <= tx_stat;
      end else if (plain_rd && hit_clk_sel) begin
        rdata_reg <= clk_sel_reg;
      end else if (plain_rd) begin
        rdata_reg <= USC_READ_ZERO;
      end
    end
  end
  assign BUS_RDATA  = rdata_reg;
  assign BUS_RVALID = rvalid_reg;
  assign RX_ERROR   = |rx_err_reg;
endmodule

// >>> tb/usc_checker.sv
`timescale 1ns/1ps
module usc_checker
  import usc_pkg::*;
(
  // Clock and reset
  input wire logic                  CLK,
  input wire logic                  SRST,
  // Watched ports
  input wire usc_pkg::usc_bus_req_t BUS_REQ,
  input wire logic                  BUS_WAIT,
  input wire logic                  BUS_RVALID,
  input wire logic                  UNIT_POWER_ENABLE,
  input wire logic                  RECEIVE_ENABLE,
  input wire logic                  SERIAL_BASE_CLOCK,
  input wire logic                  RX_DONE,
  input wire logic                  RX_BUF_RD,
  input wire logic [7:0]            RECEIVE_BUFFER,
  input wire logic                  RX_BUF_VALID,
  input wire logic                  RX_ERROR
);
  import usc_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic [3:0]  sel_h;
  logic [10:0] gap;
  logic        seen;
  wire         err_rd = BUS_REQ.rd && BUS_REQ.addr == USC_ADDR_RX_ERR;
  wire         rx_on  = UNIT_POWER_ENABLE && RECEIVE_ENABLE;
  // First tick after power-on has no reference, so spacing is judged from the second
  always_ff @(posedge CLK) begin
    seen <= !SRST && UNIT_POWER_ENABLE && (seen || SERIAL_BASE_CLOCK);
    gap  <= (SRST || !UNIT_POWER_ENABLE || SERIAL_BASE_CLOCK) ? 11'h0 : gap + 11'h1;
  end
  always_ff @(posedge CLK) begin
    if (SRST) sel_h <= 4'h0;
    else if (BUS_REQ.wr && BUS_REQ.addr == USC_ADDR_CLK_SEL) sel_h <= BUS_REQ.wdata[3:0];
  end
  a_wait_errread: assert property (err_rd |-> BUS_WAIT)
    else $error("no wait cycle");
  a_errread_answer: assert property (err_rd |-> ##2 BUS_RVALID)
    else $error("error status read not answered");
  a_read_clears: assert property (err_rd ##1 !RX_DONE [*3] |=> !RX_ERROR)
    else $error("flags kept after read");
  a_power_clears: assert property (!UNIT_POWER_ENABLE [*2] |=> !RX_ERROR && !RX_BUF_VALID)
    else $error("power off left state");
  a_rxoff_clears: assert property (!RECEIVE_ENABLE [*2] |=> !RX_ERROR)
    else $error("receive off left flags");
  a_overrun_hold: assert property (RX_DONE && RX_BUF_VALID && !RX_BUF_RD && rx_on |=> $stable(RECEIVE_BUFFER))
    else $error("overrun overwrote buffer");
  a_tick_space: assert property (SERIAL_BASE_CLOCK && seen && sel_h <= USC_SEL_MAX_DIV |->
    gap == (11'h1 << sel_h) - 11'h1)
    else $error("base clock spacing wrong");
  a_base_off: assert property (!UNIT_POWER_ENABLE |=> !SERIAL_BASE_CLOCK)
    else $error("base clock runs while off");
endmodule
bind usc_status_clock usc_checker u_chk (
  .CLK(CLK), .SRST(SRST), .BUS_REQ(BUS_REQ), .BUS_WAIT(BUS_WAIT), .BUS_RVALID(BUS_RVALID),
  .UNIT_POWER_ENABLE(UNIT_POWER_ENABLE), .RECEIVE_ENABLE(RECEIVE_ENABLE),
  .SERIAL_BASE_CLOCK(SERIAL_BASE_CLOCK), .RX_DONE(RX_DONE), .RX_BUF_RD(RX_BUF_RD),
  .RECEIVE_BUFFER(RECEIVE_BUFFER), .RX_BUF_VALID(RX_BUF_VALID), .RX_ERROR(RX_ERROR)
);

// >>> tb/usc_line_model.sv
`timescale 1ns/1ps
module usc_line_model
  import usc_pkg::*;
#(
  parameter int SHIFT_CYC = 16
) (
  // Clock
  input wire logic              clk,
  // Transmit shifter
  input wire logic              load,
  input wire logic [7:0]        ldata,
  output logic                  shift_done,
  // Receive shifter
  output logic                  rx_done,
  output usc_pkg::usc_rx_char_t rx_char
);
  logic [7:0] sent[$];
  int         cnt = 0;
  initial begin
    shift_done = 1'b0;
    rx_done = 1'b0;
    rx_char = '0;
  end
  always @(posedge clk) begin
    shift_done <= (load !== 1'b1) && cnt == 1;
    if (load === 1'b1) sent.push_back(ldata);
    cnt <= (load === 1'b1) ? SHIFT_CYC : (cnt != 0 ? cnt - 1 : 0);
  end
  // Only the first stop bit is reported; the character lines are scrambled outside the pulse
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    @(posedge clk) rx_done <= 1'b1;
    rx_char <= '{d, p, s, 1'b1};
    @(posedge clk) rx_done <= 1'b0;
    rx_char <= ~rx_char;
  endtask
endmodule

// >>> tb/uart_status_and_clock_select_bench.sv
`timescale 1ns/1ps
module uart_status_and_clock_select_bench;
  import usc_pkg::*;
  logic         CLK = 1'b0;
  logic         SRST = 1'b1;
  usc_bus_req_t req = '0;
  usc_parity_t  par = USC_PAR_NONE;
  logic         pwr = 1'b0, rxe = 1'b0, txe = 1'b0, tmr = 1'b0, rbr = 1'b0, twr = 1'b0;
  logic [7:0]   twd = 8'h00, rdat, rbuf, sdat, v;
  logic         rv, rbv, ld, sd, sbc, rxd, rer, tcm;
  usc_rx_char_t rch;
  int           failures = 0, checked = 0, cyc = 0, n, ncmp = 0;
  logic [15:0]  adr[4] = '{USC_ADDR_RX_ERR, 16'hff54, USC_ADDR_TX_STAT, USC_ADDR_CLK_SEL};
  always #12.5 CLK = ~CLK;
  usc_status_clock u_dut (.CLK(CLK), .SRST(SRST), .BUS_REQ(req), .BUS_WAIT(), .BUS_RVALID(rv),
    .BUS_RDATA(rdat), .UNIT_POWER_ENABLE(pwr), .RECEIVE_ENABLE(rxe), .TRANSMIT_ENABLE(txe),
    .PARITY_MODE_SELECT(par), .TIMER_CLOCK_SOURCE(tmr), .SERIAL_BASE_CLOCK(sbc), .RX_DONE(rxd),
    .RX_CHAR(rch), .RX_BUF_RD(rbr), .RECEIVE_BUFFER(rbuf), .RX_BUF_VALID(rbv), .RX_ERROR(rer),
    .TX_BUF_WR(twr), .TX_BUF_WDATA(twd), .TX_SHIFT_DONE(sd), .TX_SHIFT_LOAD(ld),
    .TX_SHIFT_DATA(sdat), .TX_COMPLETE(tcm));
  usc_line_model u_far (.clk(CLK), .load(ld), .ldata(sdat), .shift_done(sd), .rx_done(rxd), .rx_char(rch));
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK) req <= '{1'b0, 1'b1, a, d};
    @(posedge CLK) req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge CLK) req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge CLK) req <= '0;
    @(negedge CLK);
    for (int i = 0; i < 4 && rv !== 1'b1; i++) @(negedge CLK);
    chk(16'(rv), 16'h1);
    d = rdat;
  endtask
  task automatic tx(input logic [7:0] d);
    @(posedge CLK) twr <= 1'b1;
    twd <= d;
    @(posedge CLK) twr <= 1'b0;
  endtask
  // Timer source period is 16 cycles, so a 2048-cycle window holds 128 edges
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    ncmp <= ncmp + int'(tcm === 1'b1);
    tmr <= cyc[3];
    if (cyc == 60000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge CLK);
    SRST <= 1'b0;
    foreach (adr[i]) begin
      if (i < 3) wr(adr[i], 8'hff);
      rd(adr[i], v);
      chk(16'(v), 16'h0);
    end
    $display("reset test done");
    for (int k = 0; k < 13; k++) begin
      @(posedge CLK) pwr <= 1'b0;
      wr(USC_ADDR_CLK_SEL, 8'(k) | 8'hf0);
      rd(USC_ADDR_CLK_SEL, v);
      chk(16'(v), 16'(k));
      @(posedge CLK) pwr <= 1'b1;
      repeat (4) @(posedge CLK);
      n = 0;
      repeat (2048) @(negedge CLK) n += int'(sbc);
      chk(16'(n), 16'(k < 11 ? 2048 >> k : (k == 11 ? 128 : 0)));
    end
    @(posedge CLK) pwr <= 1'b0;
    wr(USC_ADDR_CLK_SEL, 8'h00);
    @(posedge CLK) pwr <= 1'b1;
    $display("clock test done");
    for (int m = 0; m < 8; m++) begin
      @(posedge CLK) rxe <= 1'b0;
      par <= usc_parity_t'(m[1:0]);
      repeat (2) @(posedge CLK);
      rxe <= 1'b1;
      u_far.send(8'h01, m[2], 1'b1);
      rd(USC_ADDR_RX_ERR, v);
      chk(16'(v), (m == 6 || m == 3) ? 16'h4 : 16'h0);
      rd(USC_ADDR_RX_ERR, v);
      chk(16'(v), 16'h0);
      chk(16'(rbuf), 16'h1);
      @(posedge CLK) rbr <= 1'b1;
      @(posedge CLK) rbr <= 1'b0;
    end
    u_far.send(8'h5a, 1'b0, 1'b0);
    u_far.send(8'ha5, 1'b0, 1'b1);
    @(negedge CLK) chk(16'(rer), 16'h1);
    rd(USC_ADDR_RX_ERR, v);
    chk(16'(v), 16'h3);
    chk(16'(rer), 16'h0);
    chk(16'(rbuf), 16'h5a);
    u_far.send(8'h00, 1'b0, 1'b0);
    @(posedge CLK) rxe <= 1'b0;
    repeat (2) @(posedge CLK);
    rxe <= 1'b1;
    rd(USC_ADDR_RX_ERR, v);
    chk(16'(v), 16'h0);
    u_far.send(8'h00, 1'b0, 1'b0);
    @(posedge CLK) pwr <= 1'b0;
    rd(USC_ADDR_RX_ERR, v);
    chk(16'(v), 16'h0);
    chk(16'(rbv), 16'h0);
    @(posedge CLK) pwr <= 1'b1;
    $display("receive test done");
    txe <= 1'b1;
    repeat (2) @(posedge CLK);
    tx(8'h3c);
    do rd(USC_ADDR_TX_STAT, v); while (v[1] === 1'b1);
    tx(8'hc3);
    rd(USC_ADDR_TX_STAT, v);
    chk(16'(v), 16'h3);
    do rd(USC_ADDR_TX_STAT, v); while (v !== 8'h00);
    chk(16'(ncmp), 16'h2);
    chk({u_far.sent[0], u_far.sent[1]}, 16'h3cc3);
    tx(8'h11);
    @(posedge CLK) txe <= 1'b0;
    repeat (2) @(posedge CLK);
    rd(USC_ADDR_TX_STAT, v);
    chk(16'(v), 16'h0);
    $display("transmit test done");
    wrap_up();
  end
endmodule
